/* hw/usct_pkg.sv */
// constants shared by the receive time-out, special character and baud block
// Functional notes
// - with feature bit 5 set, matching received characters are flagged and still stored
// - with feature bit 5 set, each received character is compared with the second xoff; match sets status bit 4
// - comparison uses only the low bits the word length selects (5 to 8)
// - character register bit 0 meets the first received data bit
// - three flow interrupts are enabled separately by enable bits 5 to 7
// - after reset the transmit interrupt is enabled and holding-empty is pending
// - only the highest pending source is reported; cts/rts rank lowest
// - data ready and time-out share one level, both enabled by enable bit 0
// - no time-out is raised while the receive fifo is empty
// - time-out count restarts at each stop bit centre and each holding read
// - time-out expires after four times word length plus twelve bit times
// - baud generator divides the master clock by a 16-bit divisor 1 to 65535
// - modem control bit 7 adds a divide-by-4 prescaler, else divide by 1
// - baud clock output runs at sixteen times the bit rate
// - software writes divisor high byte and low byte to their own registers
// - one baud generator times both transmitter and receiver
// - divisor registers are reachable only while line control bit 7 is 1
// - feature and character registers are reachable only while line control is bf
package usct_pkg;
	localparam int          USCT_FIFO_WIDTH  = 8;
	localparam int          USCT_FIFO_DEPTH  = 8;
	// register addresses per bank
	localparam logic [2:0]  USCT_A_RHR       = 3'h0;
	localparam logic [2:0]  USCT_A_IER       = 3'h1;
	localparam logic [2:0]  USCT_A_ISR       = 3'h2;
	localparam logic [2:0]  USCT_A_LCR       = 3'h3;
	localparam logic [2:0]  USCT_A_MCR       = 3'h4;
	localparam logic [2:0]  USCT_A_LSR       = 3'h5;
	localparam logic [2:0]  USCT_A_DIV_LO    = 3'h0;
	localparam logic [2:0]  USCT_A_DIV_HI    = 3'h1;
	localparam logic [2:0]  USCT_A_EFR       = 3'h2;
	localparam logic [2:0]  USCT_A_XOFF2     = 3'h7;
	localparam logic [7:0]  USCT_LCR_KEY     = 8'hbf;
	// field positions
	localparam int          USCT_LCR_DLAB    = 7;
	localparam int          USCT_MCR_PRESC   = 7;
	localparam int          USCT_EFR_SPEC    = 5;
	localparam int          USCT_IER_RX      = 0;
	localparam int          USCT_IER_THR     = 1;
	localparam int          USCT_IER_MODEM   = 3;
	localparam int          USCT_IER_SPEC    = 5;
	localparam int          USCT_IER_RTS     = 6;
	localparam int          USCT_IER_CTS     = 7;
	localparam int          USCT_LSR_DR      = 0;
	localparam int          USCT_LSR_THRE    = 5;
	// reset values
	localparam logic [7:0]  USCT_LCR_RST     = 8'h00;
	localparam logic [7:0]  USCT_IER_RST     = 8'h02;
	localparam logic [7:0]  USCT_MCR_RST     = 8'h00;
	localparam logic [7:0]  USCT_EFR_RST     = 8'h00;
	localparam logic [7:0]  USCT_XOFF2_RST   = 8'h00;
	localparam logic [15:0] USCT_DIV_RST     = 16'h0001;
	// interrupt source codes
	localparam logic [7:0]  USCT_ISR_NONE    = 8'h01;
	localparam logic [7:0]  USCT_ISR_RXRDY   = 8'h04;
	localparam logic [7:0]  USCT_ISR_RXTO    = 8'h0c;
	localparam logic [7:0]  USCT_ISR_THR     = 8'h02;
	localparam logic [7:0]  USCT_ISR_MODEM   = 8'h00;
	localparam logic [7:0]  USCT_ISR_SPEC    = 8'h10;
	localparam logic [7:0]  USCT_ISR_FLOW    = 8'h20;
	// timing counts
	localparam logic [1:0]  USCT_PRESC_LAST  = 2'h3;
	localparam logic [3:0]  USCT_SMP_LAST    = 4'hf;
	localparam logic [3:0]  USCT_WL_BASE     = 4'h5;
	localparam int          USCT_TO_MUL      = 4;
	localparam logic [5:0]  USCT_TO_ADD      = 6'h0c;
endpackage : usct_pkg

/* hw/usct_fifo_if.sv */
// carrier between the main block and its receive fifo
`timescale 1ns/1ns
`default_nettype none
interface usct_fifo_if #(parameter int WIDTH = 8);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;
	modport user  (output push_valid, push_data, pop_ready,
	               input  push_ready, pop_valid, pop_data);
	modport store (input  push_valid, push_data, pop_ready,
	               output push_ready, pop_valid, pop_data);
endinterface : usct_fifo_if
`default_nettype wire

/* hw/usct_fifo.sv */
// receive fifo with registered storage, room and empty flags
`timescale 1ns/1ns
`default_nettype none
module usct_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic   mclk,
	input  wire logic   rst_n,
	usct_fifo_if.store  f
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
		logic                        room;
		logic                        empty;
	} usct_fifo_st_type;

	usct_fifo_st_type s_r;
	usct_fifo_st_type s_nxt;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_nxt = s_r;
		push  = f.push_valid && s_r.room;
		pop   = f.pop_ready && !s_r.empty;
		if (push) begin
			s_nxt.mem[s_r.wp] = f.push_data;
			s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
		s_nxt.room  = (s_nxt.cnt != (AW+1)'(DEPTH));
		s_nxt.empty = (s_nxt.cnt == '0);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r       <= '0;
			s_r.empty <= 1'b1;
			s_r.room  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ready and valid come from flags, so the source sees back-pressure
	assign f.push_ready = s_r.room;
	assign f.pop_valid  = !s_r.empty;
	assign f.pop_data   = s_r.mem[s_r.rp];
endmodule : usct_fifo
`default_nettype wire

/* hw/usct_top.sv */
// receive time-out, special character, interrupt priority and baud generator
`timescale 1ns/1ns
`default_nettype none
module usct_top (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic [2:0]  host_addr,
	input  wire logic [7:0]  host_wdata,
	output logic      [7:0]  host_rdata_r,
	output logic             irq_r,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	input  wire logic        rx_stop_mid,
	input  wire logic        thr_empty,
	input  wire logic        modem_int,
	input  wire logic        cts_evt,
	input  wire logic        rts_evt,
	output logic             thr_wr_r,
	output logic      [7:0]  thr_data_r,
	output logic             sample_tick_r,
	output logic             baud_clock_out_n,
	output logic      [7:0]  line_control_out,
	output logic      [7:0]  feature_out
);
	typedef struct packed {
		logic [7:0]  line_control_reg;
		logic [7:0]  interrupt_enable_reg;
		logic [7:0]  modem_control_reg;
		logic [7:0]  enhanced_feature_reg;
		logic [7:0]  xoff2;
		logic [15:0] divisor;
		logic [1:0]  presc_cnt;
		logic [15:0] div_cnt;
		logic        stick;
		logic        bclk_n;
		logic [3:0]  smp_cnt;
		logic [5:0]  to_cnt;
		logic        to_flag;
		logic        spec_flag;
		logic        thr_flag;
		logic        thr_prev;
		logic        flow_flag;
		logic [7:0]  rdata;
		logic        irq;
		logic        thr_wr;
		logic [7:0]  thr_data;
	} usct_state_type;

	usct_state_type s_r;
	usct_state_type s_nxt;

	usct_fifo_if #(.WIDTH(usct_pkg::USCT_FIFO_WIDTH)) rxf ();

	usct_fifo #(
		.WIDTH (usct_pkg::USCT_FIFO_WIDTH),
		.DEPTH (usct_pkg::USCT_FIFO_DEPTH)
	) u_rx_fifo (
		.mclk  (mclk),
		.rst_n (rst_n),
		.f     (rxf.store)
	);

	logic       bank_key;
	logic       bank_div;
	logic       rhr_rd;
	logic       isr_rd;
	logic       push_ok;
	logic       presc_tick;
	logic       bit_tick;
	logic       restart;
	logic [3:0] word_len;
	logic [5:0] to_limit;
	logic [7:0] cmp_mask;
	logic       spec_hit;
	logic [7:0] isr_code;
	logic       thr_rise;

	////////////////////////////////////////////////////////////////////////
	// decode and combinational helpers
	always_comb begin
		bank_key = (s_r.line_control_reg == usct_pkg::USCT_LCR_KEY);
		bank_div = s_r.line_control_reg[usct_pkg::USCT_LCR_DLAB];
		rhr_rd   = host_rd && !bank_div
		           && (host_addr == usct_pkg::USCT_A_RHR);
		isr_rd   = host_rd && !bank_key
		           && (host_addr == usct_pkg::USCT_A_ISR);
		push_ok  = rx_valid && rxf.push_ready;
		presc_tick = !s_r.modem_control_reg[usct_pkg::USCT_MCR_PRESC]
		             || (s_r.presc_cnt == usct_pkg::USCT_PRESC_LAST);
		bit_tick = s_r.stick && (s_r.smp_cnt == usct_pkg::USCT_SMP_LAST);
		restart  = rx_stop_mid || rhr_rd;
		word_len = usct_pkg::USCT_WL_BASE
		           + {2'b00, s_r.line_control_reg[1:0]};
		to_limit = 6'(usct_pkg::USCT_TO_MUL * word_len)
		           + usct_pkg::USCT_TO_ADD;
		// bit 0 of the mask covers the first data bit received
		cmp_mask = 8'hff >> (2'h3 - s_r.line_control_reg[1:0]);
		spec_hit = push_ok
		           && s_r.enhanced_feature_reg[usct_pkg::USCT_EFR_SPEC]
		           && ((rx_data & cmp_mask) == (s_r.xoff2 & cmp_mask));
		thr_rise = thr_empty && !s_r.thr_prev;
		// fixed priority, one source at a time
		if (s_r.interrupt_enable_reg[usct_pkg::USCT_IER_RX]
		    && s_r.to_flag) begin
			isr_code = usct_pkg::USCT_ISR_RXTO;
		end else if (s_r.interrupt_enable_reg[usct_pkg::USCT_IER_RX]
		             && rxf.pop_valid) begin
			isr_code = usct_pkg::USCT_ISR_RXRDY;
		end else if (s_r.interrupt_enable_reg[usct_pkg::USCT_IER_THR]
		             && s_r.thr_flag) begin
			isr_code = usct_pkg::USCT_ISR_THR;
		end else if (s_r.interrupt_enable_reg[usct_pkg::USCT_IER_MODEM]
		             && modem_int) begin
			isr_code = usct_pkg::USCT_ISR_MODEM;
		end else if (s_r.interrupt_enable_reg[usct_pkg::USCT_IER_SPEC]
		             && s_r.spec_flag) begin
			isr_code = usct_pkg::USCT_ISR_SPEC;
		end else if ((s_r.interrupt_enable_reg[usct_pkg::USCT_IER_CTS]
		              || s_r.interrupt_enable_reg[usct_pkg::USCT_IER_RTS])
		             && s_r.flow_flag) begin
			isr_code = usct_pkg::USCT_ISR_FLOW;
		end else begin
			isr_code = usct_pkg::USCT_ISR_NONE;
		end
	end

	assign rxf.push_valid = rx_valid;
	assign rxf.push_data  = rx_data;
	assign rxf.pop_ready  = rhr_rd;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.thr_wr = 1'b0;
		s_nxt.thr_prev = thr_empty;
		// register writes, gated by the bank selected in line control
		if (host_wr) begin
			if (host_addr == usct_pkg::USCT_A_LCR) begin
				s_nxt.line_control_reg = host_wdata;
			end else if (bank_key) begin
				if (host_addr == usct_pkg::USCT_A_EFR) begin
					s_nxt.enhanced_feature_reg = host_wdata;
				end else if (host_addr == usct_pkg::USCT_A_XOFF2) begin
					s_nxt.xoff2 = host_wdata;
				end
			end else if (bank_div) begin
				if (host_addr == usct_pkg::USCT_A_DIV_LO) begin
					s_nxt.divisor[7:0] = host_wdata;
				end else if (host_addr == usct_pkg::USCT_A_DIV_HI) begin
					s_nxt.divisor[15:8] = host_wdata;
				end
			end else begin
				unique case (host_addr)
					usct_pkg::USCT_A_RHR: begin
						s_nxt.thr_wr   = 1'b1;
						s_nxt.thr_data = host_wdata;
					end
					usct_pkg::USCT_A_IER: begin
						s_nxt.interrupt_enable_reg = host_wdata;
					end
					usct_pkg::USCT_A_MCR: begin
						s_nxt.modem_control_reg = host_wdata;
					end
					default: begin
					end
				endcase
			end
		end
		// reads: answer one cycle later, held until the next read
		if (host_rd) begin
			s_nxt.rdata = 8'h00;
			if (host_addr == usct_pkg::USCT_A_LCR) begin
				s_nxt.rdata = s_r.line_control_reg;
			end else if (bank_key) begin
				if (host_addr == usct_pkg::USCT_A_EFR) begin
					s_nxt.rdata = s_r.enhanced_feature_reg;
				end else if (host_addr == usct_pkg::USCT_A_XOFF2) begin
					s_nxt.rdata = s_r.xoff2;
				end
			end else if (bank_div && host_addr == usct_pkg::USCT_A_DIV_LO) begin
				s_nxt.rdata = s_r.divisor[7:0];
			end else if (bank_div && host_addr == usct_pkg::USCT_A_DIV_HI) begin
				s_nxt.rdata = s_r.divisor[15:8];
			end else begin
				unique case (host_addr)
					usct_pkg::USCT_A_RHR: s_nxt.rdata = rxf.pop_data;
					usct_pkg::USCT_A_IER: s_nxt.rdata = s_r.interrupt_enable_reg;
					usct_pkg::USCT_A_ISR: s_nxt.rdata = isr_code;
					usct_pkg::USCT_A_MCR: s_nxt.rdata = s_r.modem_control_reg;
					usct_pkg::USCT_A_LSR: begin
						s_nxt.rdata[usct_pkg::USCT_LSR_DR]   = rxf.pop_valid;
						s_nxt.rdata[usct_pkg::USCT_LSR_THRE] = thr_empty;
					end
					default: s_nxt.rdata = 8'h00;
				endcase
			end
		end
		// baud generator shared by transmitter and receiver
		s_nxt.presc_cnt = s_r.presc_cnt + 1'b1;
		s_nxt.stick = 1'b0;
		if (s_r.divisor == 16'h0000) begin
			s_nxt.div_cnt = 16'h0000; // divisor zero stops the clock
		end else if (presc_tick) begin
			if (s_r.div_cnt >= s_r.divisor - 16'h0001) begin
				s_nxt.div_cnt = 16'h0000;
				s_nxt.stick   = 1'b1;
			end else begin
				s_nxt.div_cnt = s_r.div_cnt + 16'h0001;
			end
		end
		s_nxt.bclk_n = !s_nxt.stick;
		if (s_r.stick) begin
			s_nxt.smp_cnt = s_r.smp_cnt + 1'b1;
		end
		// receive time-out; the count parks at the limit so it fires once
		if (restart) begin
			s_nxt.to_cnt = 6'h00;
		end else if (bit_tick && s_r.to_cnt < to_limit) begin
			s_nxt.to_cnt = s_r.to_cnt + 6'h01;
		end
		if (rhr_rd || !rxf.pop_valid) begin
			s_nxt.to_flag = 1'b0;
		end
		if (bit_tick && !restart && rxf.pop_valid
		    && s_r.to_cnt == to_limit - 6'h01) begin
			s_nxt.to_flag = 1'b1;
		end
		// sticky sources: clear on reporting read, a new event wins
		if (isr_rd && isr_code == usct_pkg::USCT_ISR_THR) begin
			s_nxt.thr_flag = 1'b0;
		end
		if (host_wr && !bank_div && host_addr == usct_pkg::USCT_A_RHR) begin
			s_nxt.thr_flag = 1'b0;
		end
		if (thr_rise) begin
			s_nxt.thr_flag = 1'b1;
		end
		if (isr_rd && isr_code == usct_pkg::USCT_ISR_SPEC) begin
			s_nxt.spec_flag = 1'b0;
		end
		if (spec_hit) begin
			s_nxt.spec_flag = 1'b1;
		end
		if (isr_rd && isr_code == usct_pkg::USCT_ISR_FLOW) begin
			s_nxt.flow_flag = 1'b0;
		end
		if ((cts_evt
		     && s_r.interrupt_enable_reg[usct_pkg::USCT_IER_CTS])
		    || (rts_evt
		        && s_r.interrupt_enable_reg[usct_pkg::USCT_IER_RTS])) begin
			s_nxt.flow_flag = 1'b1;
		end
		s_nxt.irq = (isr_code != usct_pkg::USCT_ISR_NONE);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r                      <= '0;
			s_r.line_control_reg     <= usct_pkg::USCT_LCR_RST;
			s_r.interrupt_enable_reg <= usct_pkg::USCT_IER_RST;
			s_r.modem_control_reg    <= usct_pkg::USCT_MCR_RST;
			s_r.enhanced_feature_reg <= usct_pkg::USCT_EFR_RST;
			s_r.xoff2                <= usct_pkg::USCT_XOFF2_RST;
			s_r.divisor              <= usct_pkg::USCT_DIV_RST;
			s_r.bclk_n               <= 1'b1;
			s_r.thr_flag             <= 1'b1;
			s_r.thr_prev             <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign host_rdata_r     = s_r.rdata;
	assign irq_r            = s_r.irq;
	assign thr_wr_r         = s_r.thr_wr;
	assign thr_data_r       = s_r.thr_data;
	assign sample_tick_r    = s_r.stick;
	assign baud_clock_out_n = s_r.bclk_n;
	assign line_control_out = s_r.line_control_reg;
	assign feature_out      = s_r.enhanced_feature_reg;
	assign rx_ready         = rxf.push_ready;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_spec_set;
		spec_hit |=> s_r.spec_flag;
	endproperty
	a_spec_set: assert property (p_spec_set)
		else $error("special match did not set flag");

	property p_spec_short;
		(push_ok && s_r.enhanced_feature_reg[5]
		 && s_r.line_control_reg[1:0] == 2'h0
		 && rx_data[4:0] == s_r.xoff2[4:0]) |=> s_r.spec_flag;
	endproperty
	a_spec_short: assert property (p_spec_short)
		else $error("five bit match ignored");

	property p_to_needs_data;
		$rose(s_r.to_flag) |-> $past(rxf.pop_valid);
	endproperty
	a_to_needs_data: assert property (p_to_needs_data)
		else $error("time-out raised with empty fifo");

	property p_to_restart;
		rx_stop_mid |=> (s_r.to_cnt == 6'h00);
	endproperty
	a_to_restart: assert property (p_to_restart)
		else $error("time-out count not restarted");

	property p_to_expire;
		(bit_tick && !restart && rxf.pop_valid
		 && s_r.to_cnt == to_limit - 6'h01) |=> s_r.to_flag;
	endproperty
	a_to_expire: assert property (p_to_expire)
		else $error("time-out did not expire at limit");

	property p_div3;
		(s_r.stick && s_r.divisor == 16'h0003 && !s_r.modem_control_reg[7]
		 && !host_wr) ##1 !host_wr |-> !s_r.stick [*2] ##1 s_r.stick;
	endproperty
	a_div3: assert property (p_div3)
		else $error("divide by three period wrong");

	property p_presc4;
		(s_r.stick && s_r.divisor == 16'h0001 && s_r.modem_control_reg[7]
		 && !host_wr) ##1 !host_wr [*2]
		|-> (!$past(s_r.stick) && !s_r.stick) ##1 !s_r.stick ##1 s_r.stick;
	endproperty
	a_presc4: assert property (p_presc4)
		else $error("prescaler period wrong");

	property p_bclk;
		baud_clock_out_n == !sample_tick_r;
	endproperty
	a_bclk: assert property (p_bclk)
		else $error("baud clock output out of step");

	property p_reset_thr;
		$rose(rst_n) |=> irq_r;
	endproperty
	a_reset_thr: assert property (p_reset_thr)
		else $error("no transmit interrupt after reset");

	property p_flow_low;
		(s_r.thr_flag && s_r.interrupt_enable_reg[1])
		|-> (isr_code != usct_pkg::USCT_ISR_FLOW);
	endproperty
	a_flow_low: assert property (p_flow_low)
		else $error("flow source masked a higher one");

	property p_to_code;
		(s_r.to_flag && s_r.interrupt_enable_reg[0])
		|-> (isr_code == usct_pkg::USCT_ISR_RXTO);
	endproperty
	a_to_code: assert property (p_to_code)
		else $error("time-out not reported at receive level");

	property p_div_lock;
		(host_wr && !bank_div && host_addr != usct_pkg::USCT_A_LCR)
		|=> $stable(s_r.divisor);
	endproperty
	a_div_lock: assert property (p_div_lock)
		else $error("divisor written outside its bank");

	property p_efr_lock;
		(host_wr && !bank_key && host_addr == usct_pkg::USCT_A_EFR)
		|=> $stable(s_r.enhanced_feature_reg);
	endproperty
	a_efr_lock: assert property (p_efr_lock)
		else $error("feature register written outside its bank");
endmodule : usct_top
`default_nettype wire

/* sim/usct_serial_peer.sv */
// receiver stand-in that hands characters to the block
`timescale 1ns/1ns
`default_nettype none
module usct_serial_peer (
	input  wire logic       mclk,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_stop_mid
);
	logic [7:0] pend[$];
	////////////////////////////////////////////////////////////////////////
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_stop_mid = 1'b0;
		forever begin
			@(posedge mclk);
			// stop bit centre comes with each character
			rx_stop_mid <= !rx_valid && pend.size() > 0;
			if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
				// no stale byte once released
				rx_data <= ~rx_data;
			end else if (!rx_valid && pend.size() > 0) begin
				rx_valid <= 1'b1;
				rx_data <= pend.pop_front();
			end else if (!rx_valid) begin
				rx_data <= ~rx_data;
			end
		end
	end
	task send(input logic [7:0] b);
		pend.push_back(b);
	endtask : send
endmodule : usct_serial_peer
`default_nettype wire

/* sim/usct_top_tb.sv */
// self-checking bench for the usct top block
`timescale 1ns/1ns
`default_nettype none
module usct_top_tb;
	logic        mclk, rst_n, host_wr, host_rd, irq_r, rx_valid, rx_ready;
	logic        rx_stop_mid, thr_empty, modem_int, cts_evt, rts_evt;
	logic        thr_wr_r, sample_tick_r, baud_clock_out_n;
	logic        rd_q = 1'b0;
	logic [2:0]  host_addr;
	logic [7:0]  host_wdata, host_rdata_r, rx_data, thr_data_r;
	logic [7:0]  line_control_out, feature_out, a, b;
	logic [7:0]  v[9];
	logic [7:0]  exp_q[$];
	logic [31:0] rng = 32'h01fe;
	int          error_cnt = 0;
	int          n_checks = 0;
	logic [7:0]  lo[4] = '{8'h03, 8'h03, 8'h01, 8'h00};
	logic [7:0]  hi[4] = '{8'h00, 8'h00, 8'h00, 8'h01};
	logic [7:0]  mc[4] = '{8'h00, 8'h80, 8'h80, 8'h00};
	int          gp[4] = '{3, 12, 4, 256};
	////////////////////////////////////////////////////////////////////////
	usct_top uut (.mclk(mclk), .rst_n(rst_n), .host_wr(host_wr),
		.host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata_r(host_rdata_r), .irq_r(irq_r), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .rx_stop_mid(rx_stop_mid),
		.thr_empty(thr_empty), .modem_int(modem_int), .cts_evt(cts_evt),
		.rts_evt(rts_evt), .thr_wr_r(thr_wr_r), .thr_data_r(thr_data_r),
		.sample_tick_r(sample_tick_r), .baud_clock_out_n(baud_clock_out_n),
		.line_control_out(line_control_out), .feature_out(feature_out));
	usct_serial_peer peer (.mclk(mclk), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_stop_mid(rx_stop_mid));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : xs
	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task wr(input logic [2:0] ad, input logic [7:0] d);
		@(posedge mclk);
		host_wr <= 1'b1;
		host_addr <= ad;
		host_wdata <= d;
		@(posedge mclk);
		host_wr <= 1'b0;
	endtask : wr
	// expected answer is queued; the watcher compares it one edge later
	task rd(input logic [2:0] ad, input logic [7:0] e);
		@(posedge mclk);
		host_rd <= 1'b1;
		host_addr <= ad;
		exp_q.push_back(e);
		@(posedge mclk);
		host_rd <= 1'b0;
	endtask : rd
	task pulse_flow();
		@(posedge mclk);
		cts_evt <= 1'b1;
		@(posedge mclk);
		cts_evt <= 1'b0;
		rts_evt <= 1'b1;
		@(posedge mclk);
		rts_evt <= 1'b0;
	endtask : pulse_flow
	// sampled on the falling edge, where tick outputs have settled
	task next_tick(output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (sample_tick_r !== 1'b1 && n < 3000);
	endtask : next_tick
	task summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		rd_q <= host_rd;
		if (rd_q)
			check("read data", 16'(host_rdata_r), 16'(exp_q.pop_front()));
	end
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#3000000;
		error_cnt++;
		summarize();
	end
	initial begin
		int n;
		rst_n = 1'b0;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = 3'h0;
		host_wdata = 8'h00;
		thr_empty = 1'b1;
		modem_int = 1'b0;
		cts_evt = 1'b0;
		rts_evt = 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(negedge mclk);
		check("irq after reset", 16'(irq_r), 16'h0001);
		rd(3'h2, 8'h02);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(3'h3, 8'h80);
			wr(3'h0, lo[i]);
			wr(3'h1, hi[i]);
			rd(3'h0, lo[i]);
			wr(3'h3, 8'h00);
			wr(3'h4, mc[i]);
			next_tick(n);
			next_tick(n);
			check("baud out", 16'(baud_clock_out_n), 16'h0000);
			next_tick(n);
			check("tick gap", 16'(n), 16'(gp[i]));
		end
		$display("test baud done");
		// divisor 1 gives a bit time of sixteen clocks
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h00);
		wr(3'h3, 8'hbf);
		wr(3'h2, 8'h20);
		wr(3'h7, 8'hf5);
		wr(3'h3, 8'h00);
		wr(3'h4, 8'h00);
		wr(3'h1, 8'h20);
		peer.send(8'h15);
		repeat (10) @(posedge mclk);
		rd(3'h2, 8'h10);
		rd(3'h0, 8'h15);
		rd(3'h2, 8'h01);
		peer.send(8'h14);
		repeat (10) @(posedge mclk);
		rd(3'h2, 8'h01);
		rd(3'h0, 8'h14);
		$display("test special done");
		wr(3'h1, 8'hc1);
		a = xs();
		pulse_flow();
		peer.send(a);
		repeat (10) @(posedge mclk);
		rd(3'h2, 8'h04);
		rd(3'h0, a);
		rd(3'h2, 8'h20);
		$display("test priority done");
		wr(3'h1, 8'h01);
		a = xs();
		b = xs();
		peer.send(a);
		repeat (300) @(posedge mclk);
		peer.send(b);
		repeat (470) @(posedge mclk);
		rd(3'h2, 8'h04);
		repeat (80) @(posedge mclk);
		rd(3'h2, 8'h0c);
		rd(3'h0, a);
		rd(3'h0, b);
		rd(3'h5, 8'h20);
		repeat (600) @(posedge mclk);
		rd(3'h2, 8'h01);
		$display("test timeout done");
		wr(3'h1, 8'h00);
		for (int i = 0; i < 9; i++) begin
			v[i] = xs();
			peer.send(v[i]);
		end
		repeat (30) @(negedge mclk);
		check("fifo room", 16'(rx_ready), 16'h0000);
		for (int i = 0; i < 9; i++)
			rd(3'h0, v[i]);
		rd(3'h5, 8'h20);
		$display("test fifo done");
		wr(3'h1, 8'h4a);
		a = xs();
		wr(3'h0, a);
		@(negedge mclk);
		check("thr write", 16'({thr_wr_r, thr_data_r}), 16'({1'b1, a}));
		check("lcr out", 16'(line_control_out), 16'h0000);
		check("efr out", 16'(feature_out), 16'h0020);
		@(posedge mclk);
		thr_empty <= 1'b0;
		cts_evt <= 1'b1;
		@(posedge mclk);
		thr_empty <= 1'b1;
		cts_evt <= 1'b0;
		modem_int <= 1'b1;
		repeat (2) @(negedge mclk);
		check("irq pending", 16'(irq_r), 16'h0001);
		rd(3'h2, 8'h02);
		rd(3'h2, 8'h00);
		modem_int <= 1'b0;
		rd(3'h2, 8'h01);
		$display("test transmit done");
		repeat (5) @(posedge mclk);
		summarize();
	end
endmodule : usct_top_tb
`default_nettype wire
